// ### lp_weight_pkg.sv
// constants for the perceptual weighting filter
// assumes Q15 coefficients and 16-bit samples from the pre-emphasis stage
package lp_weight_pkg;
    localparam int unsigned SAMPLE_W        = 16;
    localparam int unsigned COEF_W          = 16;
    localparam int unsigned ACC_W           = 40;
    localparam int unsigned FRAC_BITS       = 15;
    localparam int unsigned LP_ORDER        = 16;
    localparam int unsigned SUBFRAME_LEN    = 64;
    localparam int unsigned SF_PER_FRAME_LO = 4;
    localparam int unsigned SF_PER_FRAME_HI = 5;
    localparam int unsigned SUBFRAME_MS_LO  = 5;
    localparam int unsigned SUBFRAME_MS_HI  = 4;
    localparam logic [15:0] RATE_SPLIT_KBPS_X10  = 16'h0084;
    localparam logic [15:0] LP_BYPASS_KBPS_X10   = 16'h0280;
    localparam logic [15:0] INT_RATE_LO_HZ_DIV10 = 16'h0500;
    localparam logic [15:0] INT_RATE_HI_HZ_DIV10 = 16'h0640;
    localparam logic signed [COEF_W-1:0] BETA1_Q15 = 16'sh570A;
    localparam logic [1:0] BW_NB = 2'h0;
    localparam int unsigned TAP_CNT_W = 5;
    localparam int unsigned SMP_CNT_W = 6;
    localparam int unsigned SF_CNT_W  = 3;
endpackage

// ### lp_weight_mac.sv
// one multiply-accumulate step of the weighting sum
// assumes Q15 coefficient and signed sample operands
`timescale 1ns/1ps
`default_nettype none
module lp_weight_mac
    import lp_weight_pkg::*;
(
    // operands
    input  wire logic signed [ACC_W-1:0]    acc_i,
    input  wire logic signed [COEF_W-1:0]   coef_i,
    input  wire logic signed [SAMPLE_W-1:0] smp_i,
    // result
    output logic signed [ACC_W-1:0]         acc_o
);
    logic signed [COEF_W+SAMPLE_W-1:0] prod;
    always_comb begin
        prod  = coef_i * smp_i;
        acc_o = acc_i + ACC_W'(prod);
    end
endmodule
`default_nettype wire

// ### lp_perceptual_weighting.sv
// perceptual weighting filter, one tap per clock, plus rate and subframe select
// assumes the coefficient source holds a set ready at every subframe boundary
//
// Function
// - 12.8 kHz up to 13.2 kb/s, else 16 kHz
// - narrowband input always uses 12.8 kHz
// - subframes are exactly 64 samples
// - four 5 ms or five 4 ms subframes
// - bypass the path above 64 kb/s
// - numerator weighted LP, denominator beta1 0.68
// - output input plus weighted taps plus feedback
// - coefficients and input are pre-emphasised signal
// - new coefficient set loaded each subframe boundary
`timescale 1ns/1ps
`default_nettype none
module lp_perceptual_weighting
    import lp_weight_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_n_i,
    // configuration
    input  wire logic [15:0]                bitrate_x10_i,
    input  wire logic [1:0]                 bandwidth_i,
    // coefficient source: a_i * gamma1^i in Q15, index 0 is tap 1
    input  wire logic                       coef_valid_i,
    input  wire logic signed [COEF_W-1:0]   coef_i [LP_ORDER],
    output logic                            coef_ready_o,
    // pre-emphasised sample input
    input  wire logic                       in_valid_i,
    input  wire logic signed [SAMPLE_W-1:0] in_sample_i,
    output logic                            in_ready_o,
    // weighted sample output
    output logic                            out_valid_o,
    output logic signed [SAMPLE_W-1:0]      out_sample_o,
    output logic                            out_sf_last_o,
    output logic                            out_frame_last_o,
    // rate status
    output logic                            rate_hi_o,
    output logic [2:0]                      sf_per_frame_o,
    output logic                            lp_bypass_o
);
    typedef enum logic [3:0] {
        ST_LOAD = 4'h1,
        ST_IDLE = 4'h2,
        ST_MAC  = 4'h4,
        ST_OUT  = 4'h8
    } state_t;

    function automatic logic signed [SAMPLE_W-1:0] sat_q15(input logic signed [ACC_W-1:0] a);
        logic signed [ACC_W-1:0] s;
        s = a >>> FRAC_BITS;
        if (s > ACC_W'(32767))
            sat_q15 = 16'sh7FFF;
        else if (s < -ACC_W'(32768))
            sat_q15 = 16'sh8000;
        else
            sat_q15 = s[SAMPLE_W-1:0];
    endfunction

    state_t                        state_q, state_d;
    logic signed [COEF_W-1:0]      coef_q [LP_ORDER];
    logic signed [COEF_W-1:0]      coef_d [LP_ORDER];
    logic signed [SAMPLE_W-1:0]    hist_q [LP_ORDER];
    logic signed [SAMPLE_W-1:0]    hist_d [LP_ORDER];
    logic signed [SAMPLE_W-1:0]    cur_q, cur_d;
    logic signed [SAMPLE_W-1:0]    yprev_q, yprev_d;
    logic signed [ACC_W-1:0]       acc_q, acc_d, mac_res;
    logic signed [COEF_W-1:0]      mac_coef;
    logic signed [SAMPLE_W-1:0]    mac_smp;
    logic [TAP_CNT_W-1:0]          tap_q, tap_d;
    logic [SMP_CNT_W-1:0]          smp_q, smp_d;
    logic [SF_CNT_W-1:0]           sf_q, sf_d;
    logic                          ov_q, ov_d;
    logic signed [SAMPLE_W-1:0]    osmp_q, osmp_d;
    logic                          osf_q, osf_d, ofr_q, ofr_d;
    logic                          rate_hi;
    logic [SF_CNT_W-1:0]           sf_max;

    // narrowband forces the low rate regardless of bitrate
    always_comb begin
        rate_hi = (bitrate_x10_i > RATE_SPLIT_KBPS_X10) && (bandwidth_i != BW_NB);
        sf_max  = rate_hi ? SF_CNT_W'(SF_PER_FRAME_HI - 1) : SF_CNT_W'(SF_PER_FRAME_LO - 1);
    end

    assign rate_hi_o      = rate_hi;
    assign sf_per_frame_o = sf_max + 3'h1;
    assign lp_bypass_o    = bitrate_x10_i > LP_BYPASS_KBPS_X10;
    assign coef_ready_o   = (state_q == ST_LOAD) && !lp_bypass_o;
    assign in_ready_o     = (state_q == ST_IDLE) && !lp_bypass_o;
    assign out_valid_o      = ov_q;
    assign out_sample_o     = osmp_q;
    assign out_sf_last_o    = osf_q;
    assign out_frame_last_o = ofr_q;

    // taps walk 0..15, then the beta1 feedback term
    always_comb begin
        if (tap_q == TAP_CNT_W'(LP_ORDER)) begin
            mac_coef = BETA1_Q15;
            mac_smp  = yprev_q;
        end else begin
            mac_coef = coef_q[tap_q[3:0]];
            mac_smp  = hist_q[tap_q[3:0]];
        end
    end

    lp_weight_mac u_mac (
        .acc_i  (acc_q),
        .coef_i (mac_coef),
        .smp_i  (mac_smp),
        .acc_o  (mac_res)
    );

    always_comb begin
        state_d = state_q;
        coef_d  = coef_q;
        hist_d  = hist_q;
        cur_d   = cur_q;
        yprev_d = yprev_q;
        acc_d   = acc_q;
        tap_d   = tap_q;
        smp_d   = smp_q;
        sf_d    = sf_q;
        ov_d    = 1'b0;
        osmp_d  = osmp_q;
        osf_d   = 1'b0;
        ofr_d   = 1'b0;
        unique case (state_q)
            ST_LOAD: begin
                if (coef_valid_i && !lp_bypass_o) begin
                    coef_d  = coef_i;
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (in_valid_i && !lp_bypass_o) begin
                    cur_d   = in_sample_i;
                    acc_d   = ACC_W'(in_sample_i) <<< FRAC_BITS;
                    tap_d   = '0;
                    state_d = ST_MAC;
                end
            end
            ST_MAC: begin
                acc_d = mac_res;
                tap_d = tap_q + 5'h01;
                if (tap_q == TAP_CNT_W'(LP_ORDER))
                    state_d = ST_OUT;
            end
            ST_OUT: begin
                osmp_d  = sat_q15(acc_q);
                yprev_d = sat_q15(acc_q);
                ov_d    = 1'b1;
                for (int i = LP_ORDER - 1; i > 0; i--)
                    hist_d[i] = hist_q[i-1];
                hist_d[0] = cur_q;
                smp_d     = smp_q + 6'h01;
                state_d   = ST_IDLE;
                if (smp_q == SMP_CNT_W'(SUBFRAME_LEN - 1)) begin
                    osf_d   = 1'b1;
                    state_d = ST_LOAD;
                    if (sf_q >= sf_max) begin
                        ofr_d = 1'b1;
                        sf_d  = '0;
                    end else begin
                        sf_d = sf_q + 3'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_LOAD;
            for (int i = 0; i < LP_ORDER; i++) begin
                coef_q[i] <= '0;
                hist_q[i] <= '0;
            end
            cur_q   <= '0;
            yprev_q <= '0;
            acc_q   <= '0;
            tap_q   <= '0;
            smp_q   <= '0;
            sf_q    <= '0;
            ov_q    <= 1'b0;
            osmp_q  <= '0;
            osf_q   <= 1'b0;
            ofr_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            coef_q  <= coef_d;
            hist_q  <= hist_d;
            cur_q   <= cur_d;
            yprev_q <= yprev_d;
            acc_q   <= acc_d;
            tap_q   <= tap_d;
            smp_q   <= smp_d;
            sf_q    <= sf_d;
            ov_q    <= ov_d;
            osmp_q  <= osmp_d;
            osf_q   <= osf_d;
            ofr_q   <= ofr_d;
        end
    end

    // 1 take + 17 mac + 1 out cycles from sample accept to output
    sequence s_take;
        in_valid_i && in_ready_o;
    endsequence
    sequence s_done;
        ##19 out_valid_o;
    endsequence

    a_out_latency: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        s_take |-> s_done)
        else $error("output not 19 cycles after accept");
    a_rate_select: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rate_hi_o == ((bitrate_x10_i > 16'h0084) && (bandwidth_i != 2'h0)))
        else $error("internal rate select wrong");
    a_nb_low_rate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (bandwidth_i == 2'h0) |-> (sf_per_frame_o == 3'h4))
        else $error("narrowband not at low rate");
    a_sf_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        out_sf_last_o |-> $past(smp_q, 2) == 6'h3F)
        else $error("subframe not 64 samples");
    a_frame_end: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        out_frame_last_o |-> out_sf_last_o && ($past(sf_q) == sf_max))
        else $error("frame end at wrong subframe");
    a_bypass_idle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        lp_bypass_o |-> !in_ready_o && !coef_ready_o)
        else $error("path active while bypassed");
    a_beta_tap: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_q == ST_MAC && tap_q == 5'h10) |-> mac_coef == 16'sh570A)
        else $error("feedback coefficient wrong");
    a_load_after_sf: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        out_sf_last_o |-> state_q == ST_LOAD)
        else $error("no coefficient load at boundary");
    a_hist_shift: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        out_valid_o |-> hist_q[0] == $past(cur_q))
        else $error("history not shifted");
endmodule
`default_nettype wire

// ### lp_src_model.sv
// upstream stand-in: offers one coefficient set per subframe and a sample stream
// assumes the bench refreshes set_i and smp_i right after each take
`timescale 1ns/1ps
`default_nettype none
module lp_src_model
    import lp_weight_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_n_i,
    // bench side
    input  wire logic                       en_i,
    input  wire logic                       slow_i,
    input  wire logic signed [COEF_W-1:0]   set_i [LP_ORDER],
    input  wire logic signed [SAMPLE_W-1:0] smp_i,
    // filter side
    input  wire logic                       coef_ready_i,
    input  wire logic                       in_ready_i,
    output logic                            coef_valid_o,
    output logic signed [COEF_W-1:0]        coef_o [LP_ORDER],
    output logic                            in_valid_o,
    output logic signed [SAMPLE_W-1:0]      in_sample_o
);
    logic       took_q;
    logic [1:0] gap_q;

    initial begin
        took_q = 1'b0;
        gap_q = 2'h0;
        coef_valid_o = 1'b0;
        in_valid_o = 1'b0;
        in_sample_o = 16'h0000;
        foreach (coef_o[k]) coef_o[k] = 16'h0000;
    end
    always @(posedge core_clk_i) begin
        took_q <= in_valid_o && in_ready_i;
    end
    always @(negedge core_clk_i) begin
        // gamma1 powers already folded into the set
        coef_valid_o <= reset_n_i && en_i;
        coef_o       <= set_i;
        if (took_q || !reset_n_i || !en_i) begin
            in_valid_o  <= 1'b0;
            in_sample_o <= ~in_sample_o;    // released line shows no stale value
            gap_q       <= slow_i ? 2'h3 : 2'h0;
        end else if (!in_valid_o && gap_q != 2'h0) begin
            in_sample_o <= ~in_sample_o;
            gap_q       <= gap_q - 2'h1;
        end else if (!in_valid_o) begin
            in_valid_o  <= 1'b1;
            in_sample_o <= smp_i;
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// bench for the weighting filter: rate table, four frames, bypass stall, mid-run reset
// assumes lp_src_model stands for the upstream stages
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lp_weight_pkg::*;
    logic                       core_clk_i, reset_n_i, en, slow, c_vld, c_rdy, i_vld, i_rdy;
    logic                       o_vld, sf_last, fr_last, hi, byp;
    logic [15:0]                bitrate;
    logic [1:0]                 bw;
    logic [2:0]                 nsf;
    logic signed [COEF_W-1:0]   next_set [LP_ORDER], coef [LP_ORDER];
    logic signed [SAMPLE_W-1:0] next_smp, i_smp, o_smp;
    logic [31:0]                seed = 32'hB50BB2C1;
    logic [15:0]                brs [6] = '{16'h0084, 16'h0085, 16'h00F4, 16'h0280, 16'h0281, 16'h0000};
    logic [1:0]                 bws [6] = '{2'h1, 2'h3, 2'h0, 2'h2, 2'h1, 2'h0};
    longint                     cur [LP_ORDER], hist [LP_ORDER], y_prev, acc, exp_q [$];
    int                         failures, num_checks, cyc, n_out, n_sf, nsf_e, t_q [$];

    lp_perceptual_weighting u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .bitrate_x10_i(bitrate), .bandwidth_i(bw), .coef_valid_i(c_vld), .coef_i(coef),
        .coef_ready_o(c_rdy), .in_valid_i(i_vld), .in_sample_i(i_smp), .in_ready_o(i_rdy),
        .out_valid_o(o_vld), .out_sample_o(o_smp), .out_sf_last_o(sf_last),
        .out_frame_last_o(fr_last), .rate_hi_o(hi), .sf_per_frame_o(nsf), .lp_bypass_o(byp));
    lp_src_model u_src (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .en_i(en),
        .slow_i(slow), .set_i(next_set), .smp_i(next_smp), .coef_ready_i(c_rdy),
        .in_ready_i(i_rdy), .coef_valid_o(c_vld), .coef_o(coef), .in_valid_o(i_vld),
        .in_sample_o(i_smp));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic new_set();
        // small taps keep the feedback loop clear of saturation
        foreach (next_set[k]) next_set[k] = COEF_W'(signed'(rnd()) >>> 20);
    endtask
    task automatic chk(string nm, logic signed [39:0] e, logic signed [39:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (60000) @(posedge core_clk_i);
        failures++;
        $display("watchdog expired");
        finish_test();
    end

    // reference filter, fed by what the handshakes hand over
    always @(posedge core_clk_i) begin
        cyc++;
        if (!reset_n_i) begin
            // encoder reset empties the filter state
            foreach (cur[k]) begin
                cur[k] = 0;
                hist[k] = 0;
            end
            y_prev = 0;
        end
        if (reset_n_i && c_vld && c_rdy) begin
            foreach (cur[k]) cur[k] = coef[k];
            new_set();
        end
        if (reset_n_i && i_vld && i_rdy) begin
            acc = longint'(i_smp) * 32768 + longint'(BETA1_Q15) * y_prev;
            foreach (cur[k]) acc += cur[k] * hist[k];
            for (int k = LP_ORDER - 1; k > 0; k--) hist[k] = hist[k - 1];
            hist[0] = i_smp;
            y_prev = acc >>> 15;
            if (y_prev > 32767) y_prev = 32767;
            if (y_prev < -32768) y_prev = -32768;
            exp_q.push_back(y_prev);
            t_q.push_back(cyc);
            next_smp = SAMPLE_W'(signed'(rnd()) >>> 21);
        end
    end
    always @(negedge core_clk_i) begin
        if (reset_n_i && o_vld) begin
            chk("weighted sample", exp_q.pop_front(), o_smp);
            // looked at half a cycle early: the next edge samples the pulse
            chk("latency", 19, cyc + 1 - t_q.pop_front());
            chk("subframe end", n_out % 64 == 63, sf_last);
            chk("frame end", n_out % 64 == 63 && n_sf == nsf_e - 1, fr_last);
            n_out++;
            if (n_out % 64 == 0) n_sf = (n_sf + 1) % nsf_e;
        end
    end

    task automatic rate_case(logic [15:0] br, logic [1:0] b);
        @(negedge core_clk_i);
        bitrate = br;
        bw = b;
        @(posedge core_clk_i);
        #1;
        chk("internal rate", b != BW_NB && br > 16'h0084, hi);
        chk("subframes", (b != BW_NB && br > 16'h0084) ? 5 : 4, nsf);
        chk("bypass", br > 16'h0280, byp);
    endtask
    task automatic wait_out(int tgt);
        int w;
        w = 0;
        while (n_out < tgt && w < 30000) begin
            @(posedge core_clk_i);
            #1;
            w++;
        end
        chk("outputs", tgt, n_out);
    endtask
    task automatic frame(string nm, logic [15:0] br, logic [1:0] b, logic s, int n, int stall);
        int base;
        base = n_out;
        @(negedge core_clk_i);
        bitrate = br;
        bw = b;
        slow = s;
        nsf_e = n;
        en = 1'b1;
        if (stall > 0) begin
            // enter bypass at a subframe edge, nothing in flight
            wait_out(base + stall);
            @(negedge core_clk_i);
            bitrate = 16'h02BC;
            repeat (40) begin
                @(posedge core_clk_i);
                #1;
                chk("sample ready in bypass", 0, i_rdy);
                chk("coef ready in bypass", 0, c_rdy);
            end
            @(negedge core_clk_i);
            bitrate = br;
        end
        wait_out(base + n * 64);
        en = 1'b0;
        $display("test %s done", nm);
    endtask

    initial begin
        en = 1'b0;
        slow = 1'b0;
        bitrate = 16'h0000;
        bw = 2'h1;
        new_set();
        next_smp = 16'h0000;
        reset_n_i = 1'b0;
        repeat (16) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        foreach (brs[i]) rate_case(brs[i], bws[i]);
        $display("test rate table done");
        frame("low rate", 16'h0084, 2'h1, 1'b0, 4, 0);
        frame("high rate bypass", 16'h00F4, 2'h2, 1'b1, 5, 128);
        frame("narrowband", 16'h00F4, BW_NB, 1'b0, 4, 0);
        // reset at a frame edge, then filter again from cleared history
        @(negedge core_clk_i);
        reset_n_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk("valid in reset", 0, o_vld);
        chk("sample in reset", 0, o_smp);
        reset_n_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        chk("coef ready after reset", 1, c_rdy);
        frame("after reset", 16'h0050, 2'h3, 1'b0, 4, 0);
        finish_test();
    end
endmodule
`default_nettype wire
